// *** bench/power_stage_model.sv ***
module power_stage_model (
    // Clock
    input  wire logic       clock,
    // Gate and pin pattern
    input  wire logic       gate_drive,
    input  wire logic [1:0] ovp_mode,
    // Comparators
    output logic            peak_reached,
    output logic            line_compensation_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int on_cnt = 0;
    int off_cnt = 0;
    always @(posedge clock) begin
        on_cnt <= gate_drive ? on_cnt + 1 : 0;
        off_cnt <= gate_drive ? 0 : off_cnt + 1;
    end
    // Current reaches the set point after a fixed ramp
    assign peak_reached = on_cnt >= 60;
    // Mode 2 stays inside blanking, mode 3 is too short once blanking ends
    assign line_compensation_pin = !gate_drive && (ovp_mode == 2'd1 ||
        (ovp_mode == 2'd2 && off_cnt < 15) || (ovp_mode == 2'd3 && off_cnt < 26));
endmodule : power_stage_model

// *** bench/prot_seq_monitor.sv ***
module prot_seq_monitor
    import prot_seq_pkg::*;
#(
    parameter int unsigned OVERLOAD_LIMIT   = 200,
    parameter int unsigned SOFT_START_LIMIT = 100
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // Observed levels
    input wire logic [11:0] feedback_level,
    input wire logic        gate_drive,
    input wire logic [11:0] peak_set_mv,
    input wire logic [11:0] ramp_mv,
    input wire logic        skip_active,
    input wire logic        latched,
    input wire logic        supply_clamp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [9:0] on_q;
    // Longest on-time, so a stuck gate shows within one floor period
    always_ff @(posedge clock) begin
        on_q <= (!rst_b || !gate_drive) ? 10'h000 : on_q + 10'h001;
    end
    sequence released;
        $rose(rst_b);
    endsequence
    sequence latch_on;
        $rose(latched);
    endsequence
    AST_RAMP_OFF: assert property (!gate_drive [*2] |-> ramp_mv == 12'h000)
        else $error("ramp present in off time");
    AST_RAMP_MAX: assert property (ramp_mv <= RAMP_FULL_MV)
        else $error("ramp above full swing");
    AST_DUTY: assert property (on_q <= 10'(PERIOD_MAX_CYCLES * DUTY_MAX_PCT / 100))
        else $error("on-time beyond duty limit");
    AST_PEAK_MAX: assert property (peak_set_mv <= SET_MAX_MV)
        else $error("set point above maximum");
    AST_PEAK_FROZEN: assert property ((feedback_level < TRACK_FLOOR_MV) [*4]
        |-> peak_set_mv <= SET_FROZEN_MV)
        else $error("set point not frozen");
    AST_SKIP: assert property (skip_active [*2] |-> !$rose(gate_drive))
        else $error("pulse during skip");
    AST_LATCH_GATE: assert property (latched |-> !gate_drive)
        else $error("gate high while latched");
    AST_LATCH_HOLD: assert property (latch_on |=> latched [*8])
        else $error("latch released");
    AST_CLAMP: assert property (supply_clamp == latched)
        else $error("clamp differs from latch");
    AST_RELEASE: assert property (released |-> !gate_drive && !latched)
        else $error("outputs active after reset");
endmodule : prot_seq_monitor

bind prot_seq prot_seq_monitor #(
    .OVERLOAD_LIMIT  (OVERLOAD_LIMIT),
    .SOFT_START_LIMIT(SOFT_START_LIMIT)
) i_prot_seq_monitor (
    .clock(clock), .rst_b(rst_b), .feedback_level(feedback_level),
    .gate_drive(gate_drive), .peak_set_mv(peak_set_mv), .ramp_mv(ramp_mv),
    .skip_active(skip_active), .latched(latched), .supply_clamp(supply_clamp)
);

// *** bench/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import prot_seq_pkg::*;
    localparam int unsigned OVL = 200;
    localparam int unsigned SS  = 100;
    logic clock = 0, rst_b = 0, early_foldback = 0, supply_start = 0;
    logic supply_low = 0, overload_flag = 0, gate_q = 0;
    logic [11:0] feedback_level = 12'h7D0;
    logic [1:0]  ovp_mode = 2'd0;
    wire peak_reached, line_compensation_pin, gate_drive, skip_active, latched, supply_clamp;
    wire [11:0] peak_set_mv, ramp_mv;
    int fail_count = 0, total_checks = 0, cyc = 0, n, p_hi, p_mid, p_lo;
    always #25 clock = ~clock;
    always @(posedge clock) gate_q <= gate_drive;
    prot_seq #(.OVERLOAD_LIMIT(OVL), .SOFT_START_LIMIT(SS)) i_prot_seq (
        .clock(clock), .rst_b(rst_b), .early_foldback(early_foldback),
        .feedback_level(feedback_level), .supply_start(supply_start),
        .supply_low(supply_low), .overload_flag(overload_flag),
        .line_compensation_pin(line_compensation_pin), .peak_reached(peak_reached),
        .gate_drive(gate_drive), .peak_set_mv(peak_set_mv), .ramp_mv(ramp_mv),
        .skip_active(skip_active), .latched(latched), .supply_clamp(supply_clamp));
    power_stage_model i_power_stage_model (
        .clock(clock), .gate_drive(gate_drive), .ovp_mode(ovp_mode),
        .peak_reached(peak_reached), .line_compensation_pin(line_compensation_pin));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // Hang guard well above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            results();
        end
    end
    task cycles(input int k);
        repeat (k) @(posedge clock);
    endtask : cycles
    // Counts edges up to the next gate rise, 3000 meaning none came
    task next_rise(output int c);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (!(gate_drive && !gate_q) && c < 3000);
    endtask : next_rise
    task power_up(input logic early);
        rst_b <= 1'b0;
        early_foldback <= early;
        supply_start <= 1'b0;
        supply_low <= 1'b0;
        overload_flag <= 1'b0;
        ovp_mode <= 2'd0;
        feedback_level <= 12'h7D0;
        cycles(8);
        @(negedge clock);
        check("reset gate", 12'(gate_drive), 12'h000);
        check("reset latch", 12'(latched), 12'h000);
        check("reset set point", peak_set_mv, SET_MAX_MV);
        @(posedge clock);
        rst_b <= 1'b1;
        supply_start <= 1'b1;
        cycles(SS + 500);
    endtask : power_up
    task supply_cycle;
        supply_start <= 1'b0;
        supply_low <= 1'b1;
        cycles(20);
        supply_low <= 1'b0;
        supply_start <= 1'b1;
    endtask : supply_cycle
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_fold;
        power_up(1'b0);
        next_rise(n);
        next_rise(p_hi);
        check("tracking set point", peak_set_mv, 12'h1DC);
        feedback_level <= 12'h4B0;
        cycles(1600);
        next_rise(n);
        next_rise(p_mid);
        feedback_level <= 12'h15E;
        cycles(1600);
        next_rise(n);
        next_rise(p_lo);
        check("folded period", 12'(p_mid > p_hi), 12'h001);
        check("lower period", 12'(p_lo > p_mid), 12'h001);
        check("floor period", 12'(p_lo), 12'(PERIOD_MAX_CYCLES));
        check("frozen set point", peak_set_mv, SET_FROZEN_MV);
        feedback_level <= 12'h0C8;
        cycles(2000);
        next_rise(n);
        check("skip flag", 12'(skip_active), 12'h001);
        check("no pulse in skip", 12'(n >= 3000), 12'h001);
        feedback_level <= 12'h3E8;
        cycles(1600);
        check("no skip above knee", 12'(skip_active), 12'h000);
        $display("foldback test done");
    endtask : t_fold
    task t_early;
        power_up(1'b1);
        feedback_level <= 12'h3E8;
        cycles(2000);
        check("early skip", 12'(skip_active), 12'h001);
        $display("early variant test done");
    endtask : t_early
    task t_ovp;
        power_up(1'b0);
        ovp_mode <= 2'd2;
        repeat (6) next_rise(n);
        check("blanked pulse", 12'(latched), 12'h000);
        ovp_mode <= 2'd3;
        repeat (6) next_rise(n);
        check("short pulse", 12'(latched), 12'h000);
        ovp_mode <= 2'd1;
        repeat (3) next_rise(n);
        ovp_mode <= 2'd0;
        next_rise(n);
        ovp_mode <= 2'd1;
        repeat (3) next_rise(n);
        check("broken run", 12'(latched), 12'h000);
        ovp_mode <= 2'd0;
        next_rise(n);
        ovp_mode <= 2'd1;
        cycles(5 * PERIOD_MIN_CYCLES);
        check("latch after run", 12'(latched), 12'h001);
        check("ramp in off time", ramp_mv, 12'h000);
        check("gate off", 12'(gate_drive), 12'h000);
        check("clamp", 12'(supply_clamp), 12'h001);
        ovp_mode <= 2'd0;
        supply_cycle();
        cycles(SS + 1000);
        check("latch holds", 12'(latched), 12'h001);
        $display("latch test done");
    endtask : t_ovp
    task t_ovl;
        power_up(1'b0);
        overload_flag <= 1'b1;
        cycles(OVL + 1000);
        next_rise(n);
        check("overload stop", 12'(n >= 3000), 12'h001);
        check("no latch", 12'(latched), 12'h000);
        supply_cycle();
        next_rise(n);
        check("restart", 12'(n < 3000), 12'h001);
        cycles(OVL + 1000);
        next_rise(n);
        check("hiccup again", 12'(n >= 3000), 12'h001);
        overload_flag <= 1'b0;
        supply_cycle();
        cycles(SS + OVL + 1000);
        next_rise(n);
        check("recovered", 12'(n < 3000), 12'h001);
        $display("overload test done");
    endtask : t_ovl
    initial begin
        t_fold();
        t_early();
        t_ovp();
        t_ovl();
        results();
    end
endmodule : tb_top

// *** rtl/ovp_qualifier.sv ***
module ovp_qualifier
    import prot_seq_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Switching cycle markers
    input  wire logic turn_off,
    input  wire logic cycle_start,
    input  wire logic off_time,
    // Synchronised comparator
    input  wire logic comp_high,
    // Result
    output logic      latch_request
);
    import prot_seq_pkg::*;

    // ------------------------------------------------------------------
    // Blanking and qualification
    // ------------------------------------------------------------------
    logic [5:0] blank_q;
    logic [5:0] high_q;
    logic       seen_q;
    logic [2:0] count_q;

    wire blanking  = (blank_q != 6'h00);
    wire qualified = (high_q == 6'(QUALIFY_CYCLES - 1)) && comp_high;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            blank_q <= 6'h00;
            high_q  <= 6'h00;
        end else begin
            blank_q <= turn_off ? 6'(BLANK_CYCLES) : (blanking ? blank_q - 6'h01 : 6'h00);
            // Short pulses reset the run and are dropped
            high_q  <= (!blanking && off_time && comp_high && !seen_q && !qualified)
                       ? high_q + 6'h01 : 6'h00;
        end
    end

    // ------------------------------------------------------------------
    // Successive event counter
    // ------------------------------------------------------------------
    // One event per cycle at most, so a noisy pin cannot fill the count at once
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            seen_q  <= 1'b0;
            count_q <= 3'h0;
        end else if (cycle_start) begin
            seen_q  <= 1'b0;
            // Event on the closing edge still belongs to this cycle
            if (qualified && !seen_q) begin
                if (count_q != 3'(EVENT_COUNT)) count_q <= count_q + 3'h1;
            end else if (!seen_q) begin
                count_q <= 3'h0;
            end
        end else if (qualified && !seen_q) begin
            seen_q  <= 1'b1;
            if (count_q != 3'(EVENT_COUNT)) count_q <= count_q + 3'h1;
        end
    end

    assign latch_request = (count_q == 3'(EVENT_COUNT));

endmodule : ovp_qualifier

// *** rtl/prot_seq.sv ***
module prot_seq
    import prot_seq_pkg::*;
#(
    parameter int unsigned OVERLOAD_LIMIT   = OVERLOAD_CYCLES,
    parameter int unsigned SOFT_START_LIMIT = SOFT_START_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Variant strap
    input  wire logic        early_foldback,
    // Analog levels from converters, in millivolts
    input  wire logic [11:0] feedback_level,
    // Comparators, asynchronous
    input  wire logic        supply_start,
    input  wire logic        supply_low,
    input  wire logic        overload_flag,
    input  wire logic        line_compensation_pin,
    input  wire logic        peak_reached,
    // Gate drive and set points
    output logic             gate_drive,
    output logic      [11:0] peak_set_mv,
    output logic      [11:0] ramp_mv,
    output logic             skip_active,
    output logic             latched,
    output logic             supply_clamp
);
    import prot_seq_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // No reset here, so the strap is settled when reset lifts
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    always_ff @(posedge clock) begin
        sync1_q <= {early_foldback, supply_start, supply_low, overload_flag,
                    line_compensation_pin, peak_reached};
        sync2_q <= sync1_q;
    end
    wire start_s = sync2_q[4];
    wire low_s   = sync2_q[3];
    wire fault_s = sync2_q[2];
    wire ovp_s   = sync2_q[1];
    wire peak_s  = sync2_q[0];

    // Strap caught once after reset release
    logic early_q;
    logic strap_done_q;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            early_q      <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            early_q      <= sync2_q[5];
            strap_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Foldback: period from feedback level
    // ------------------------------------------------------------------
    // Knee of the minimum frequency depends on the variant
    wire [11:0] knee_mv   = early_q ? FOLD_MV : MIN_FREQ_MV;
    wire        fold_on   = feedback_level < FOLD_MV;
    wire        at_floor  = feedback_level <= knee_mv;
    wire [11:0] span      = FOLD_MV - MIN_FREQ_MV;
    wire [11:0] depth     = FOLD_MV - feedback_level;
    wire [21:0] stretch   = 22'(depth) * 22'(PERIOD_MAX_CYCLES - PERIOD_MIN_CYCLES);
    wire [21:0] add_early = stretch / 22'(FOLD_MV - 12'h001);
    wire [21:0] add_norm  = stretch / 22'(span);
    wire [21:0] add_sel   = early_q ? add_early : add_norm;
    wire [9:0]  period_d  = !fold_on ? 10'(PERIOD_MIN_CYCLES)
                          : at_floor ? 10'(PERIOD_MAX_CYCLES)
                          : 10'(PERIOD_MIN_CYCLES) + add_sel[9:0];
    // Skip hysteresis-free: skip while below the knee point
    wire        skip_d    = feedback_level < knee_mv;

    // ------------------------------------------------------------------
    // Peak set point
    // ------------------------------------------------------------------
    wire [11:0] track_mv  = 12'((22'(feedback_level) * 22'(FB_RATIO)) / 22'(SET_DIV));
    wire [11:0] set_d     = (feedback_level <= TRACK_FLOOR_MV) ? SET_FROZEN_MV
                          : (track_mv > SET_MAX_MV) ? SET_MAX_MV : track_mv;

    // ------------------------------------------------------------------
    // Oscillator
    // ------------------------------------------------------------------
    logic [9:0] phase_q;
    logic [9:0] period_q;
    logic       on_q;
    logic       skip_q;
    mode_type   state_q;
    wire        run_ok     = (state_q == ST_RUN) || (state_q == ST_SOFT_START);
    wire        cycle_end  = phase_q >= period_q - 10'h001;
    wire [19:0] on_limit   = 20'(period_q) * 20'(DUTY_MAX_PCT) / 20'd100;
    wire        duty_stop  = 20'(phase_q) >= on_limit;
    logic       soft_stop;
    wire        turn_off   = on_q && (peak_s || duty_stop || soft_stop || !run_ok);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            phase_q  <= 10'h000;
            period_q <= 10'(PERIOD_MIN_CYCLES);
            on_q     <= 1'b0;
            skip_q   <= 1'b0;
        end else begin
            phase_q <= cycle_end ? 10'h000 : phase_q + 10'h001;
            if (cycle_end) begin
                period_q <= period_d;
                skip_q   <= skip_d;
            end
            if (cycle_end)
                on_q <= run_ok && !skip_d;
            else if (turn_off)
                on_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Protection sequencer
    // ------------------------------------------------------------------
    logic [31:0] timer_q;
    wire latch_req;
    wire timer_done_ol = timer_q >= OVERLOAD_LIMIT;
    wire timer_done_ss = timer_q >= SOFT_START_LIMIT;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= ST_WAIT_SUPPLY;
            timer_q <= 32'h0;
        end else begin
            case (state_q)
                ST_WAIT_SUPPLY: begin
                    timer_q <= 32'h0;
                    if (start_s) state_q <= ST_SOFT_START;
                end
                ST_SOFT_START: begin
                    timer_q <= timer_q + 32'h1;
                    if (latch_req) state_q <= ST_LATCHED;
                    else if (timer_done_ss) begin
                        state_q <= ST_RUN;
                        timer_q <= 32'h0;
                    end
                end
                ST_RUN: begin
                    // Timer runs only while the flag stays up
                    timer_q <= fault_s ? timer_q + 32'h1 : 32'h0;
                    if (latch_req) state_q <= ST_LATCHED;
                    else if (fault_s && timer_done_ol) state_q <= ST_HICCUP;
                end
                ST_HICCUP: begin
                    timer_q <= 32'h0;
                    if (low_s) state_q <= ST_WAIT_SUPPLY;
                end
                ST_LATCHED: begin
                    timer_q <= 32'h0;
                end
                default: state_q <= ST_WAIT_SUPPLY;
            endcase
        end
    end

    // Soft-start caps on-time, growing across the soft-start window
    wire [41:0] ss_prod = 42'(timer_q) * 42'(period_q);
    assign soft_stop = (state_q == ST_SOFT_START) &&
                       (42'(phase_q) * 42'(SOFT_START_LIMIT) >= ss_prod);

    ovp_qualifier u_ovp (
        .clock         (clock),
        .rst_b         (rst_b),
        .turn_off      (turn_off),
        .cycle_start   (cycle_end),
        .off_time      (!on_q),
        .comp_high     (ovp_s),
        .latch_request (latch_req)
    );

    ramp_gen u_ramp (
        .clock   (clock),
        .rst_b   (rst_b),
        .switch_on (on_q),
        .phase   (phase_q),
        .period  (period_q),
        .ramp_mv (ramp_mv)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gate_drive   <= 1'b0;
            peak_set_mv  <= SET_MAX_MV;
            skip_active  <= 1'b0;
            latched      <= 1'b0;
            supply_clamp <= 1'b0;
        end else begin
            gate_drive   <= on_q && !turn_off && run_ok;
            peak_set_mv  <= set_d;
            skip_active  <= skip_q;
            latched      <= state_q == ST_LATCHED;
            supply_clamp <= state_q == ST_LATCHED;
        end
    end

endmodule : prot_seq

// *** rtl/prot_seq_pkg.sv ***
// Overview of operation
// - Foldback begins below 1.5 V feedback
// - Set point tracks feedback, floors 250 mV
// - Frequency lowers to 26 kHz floor
// - Skip cycles below minimum-frequency feedback point
// - Early variant reaches minimum at 1.5 V
// - Fault held over 100 ms stops drive
// - Hiccup off until supply recharges, restart
// - Persisting fault repeats hiccup, else normal
// - Soft-start on every restart attempt
// - Compensation ramp applied only during on-time
// - Ramp full swing at 80% duty
// - Latch holds until supply cycled; here it holds through supply cycling and only reset clears it
// - Latch request from pin above 3 V
// - Blank comparator 1 us after turn-off
// - Validate events lasting at least 600 ns
// - Latch after 4 successive validated events
// - Events in consecutive switching cycles
package prot_seq_pkg;

    // ------------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_HZ       = 20_000_000;
    localparam int unsigned CLOCK_PERIOD_NS = 50;
    localparam int unsigned OVERLOAD_MS    = 100;
    localparam int unsigned OVERLOAD_CYCLES = OVERLOAD_MS * (CLOCK_HZ / 1000);
    localparam int unsigned BLANK_NS       = 1000;
    localparam int unsigned BLANK_CYCLES   =
        (BLANK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned QUALIFY_NS     = 600;
    localparam int unsigned QUALIFY_CYCLES =
        (QUALIFY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned SOFT_START_MS  = 4;
    localparam int unsigned SOFT_START_CYCLES = SOFT_START_MS * (CLOCK_HZ / 1000);
    localparam int unsigned EVENT_COUNT    = 4;

    // ------------------------------------------------------------------
    // Switching period, nominal and floor
    // ------------------------------------------------------------------
    localparam int unsigned NOMINAL_HZ     = 65_000;
    localparam int unsigned FLOOR_HZ       = 26_000;
    localparam int unsigned PERIOD_MIN_CYCLES = CLOCK_HZ / NOMINAL_HZ;
    localparam int unsigned PERIOD_MAX_CYCLES = CLOCK_HZ / FLOOR_HZ;
    localparam int unsigned DUTY_MAX_PCT   = 80;
    localparam int unsigned PERIOD_WIDTH   = 10;

    // ------------------------------------------------------------------
    // Levels in millivolts, 12-bit codes
    // ------------------------------------------------------------------
    localparam logic [11:0] FOLD_MV        = 12'h5DC;  // 1500
    localparam logic [11:0] TRACK_FLOOR_MV = 12'h41A;  // 1050
    localparam logic [11:0] SET_FROZEN_MV  = 12'h0FA;  // 250
    localparam logic [11:0] SET_MAX_MV     = 12'h320;  // 800
    localparam logic [11:0] MIN_FREQ_MV    = 12'h15E;  // 350
    localparam logic [11:0] RAMP_FULL_MV   = 12'h9C4;  // 2500
    localparam logic [11:0] LATCH_REF_MV   = 12'hBB8;  // 3000
    localparam logic [11:0] SUPPLY_LOW_MV  = 12'hDAC;  // 7 V, in 2 mV steps
    localparam logic [11:0] FB_RATIO       = 12'h00A;  // Feedback divided to set point
    localparam logic [11:0] SET_DIV        = 12'h02A;  // 4.2 in tenths

    typedef enum logic [2:0] {
        ST_WAIT_SUPPLY,
        ST_SOFT_START,
        ST_RUN,
        ST_HICCUP,
        ST_LATCHED
    } mode_type;

endpackage : prot_seq_pkg

// *** rtl/ramp_gen.sv ***
module ramp_gen
    import prot_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Oscillator
    input  wire logic        switch_on,
    input  wire logic [9:0]  phase,
    input  wire logic [9:0]  period,
    // Ramp out, in millivolts
    output logic      [11:0] ramp_mv
);
    import prot_seq_pkg::*;

    // ------------------------------------------------------------------
    // Compensation ramp
    // ------------------------------------------------------------------
    // Full swing at the maximum on-time fraction of the period
    // Product of phase, swing and percent needs 28 bits at the longest period
    wire [27:0] on_max  = 28'(period) * 28'(DUTY_MAX_PCT);
    wire [27:0] scaled  = 28'(phase) * 28'(RAMP_FULL_MV) * 28'd100;
    wire [27:0] quot    = (on_max == 28'h0) ? 28'h0 : scaled / on_max;
    wire [11:0] ramp_d  = switch_on ? ((quot > 28'(RAMP_FULL_MV)) ? RAMP_FULL_MV
                                                                 : quot[11:0]) : 12'h000;

    always_ff @(posedge clock) begin
        if (!rst_b) ramp_mv <= 12'h000;
        else        ramp_mv <= ramp_d;
    end

endmodule : ramp_gen
